// >>> common/iss_cfg.svh
// constants for the interrupt service sequencer: offsets, field positions,
// reset values. assumes a 64-bit interrupt vector and 32-bit words.
// Behaviour
// - entry stores return pc in the return register chosen by event type
// - entry selects emulation mode for emulation, supervisor mode otherwise
// - first handler op at stage two clears edge pending, sets in-service bit
// - global in-service bit is set on hardware entries and alias writes only
// - a set global in-service bit blocks hardware until alias save
// - enabled exception acts at stage two and aborts all younger ops
// - exception during hardware entry aborts it, pending bit stays set
// - global in-service bit forces priority mask bits 59..0 to zero
// - exceptions ignore global enable and global in-service bits
// - pc captured at entry, written to return register at commit
// - stage two recheck of global bits, else flush and resume
// - alias read clears, alias write sets the global in-service bit
// - return clears top in-service bit, global bit unless exception
// - non-nesting handler keeps hardware blocked for whole routine
// - the entry's own enable bit cleared in flight does not stop the entry
// - priority mask is ones above top in-service bit, else zero
// - pending and enable and priority mask, serve highest if global on
`ifndef ISS_CFG_SVH
`define ISS_CFG_SVH

`define ISS_VEC_W 64
`define ISS_PC_W 32
`define ISS_ADDR_W 8
`define ISS_DATA_W 32
`define ISS_HW_TOP 59
`define ISS_GLOBAL_BIT 60
`define ISS_EXC_BIT 62
`define ISS_EMU_BIT 63

// register byte offsets
`define ISS_OFS_PEND_LO 8'h00
`define ISS_OFS_PEND_HI 8'h04
`define ISS_OFS_PSET_LO 8'h08
`define ISS_OFS_PSET_HI 8'h0C
`define ISS_OFS_PCLR_LO 8'h10
`define ISS_OFS_PCLR_HI 8'h14
`define ISS_OFS_ENAB_LO 8'h18
`define ISS_OFS_ENAB_HI 8'h1C
`define ISS_OFS_INSV_LO 8'h20
`define ISS_OFS_INSV_HI 8'h24
`define ISS_OFS_EDGE_LO 8'h28
`define ISS_OFS_EDGE_HI 8'h2C
`define ISS_OFS_HWRET 8'h30
`define ISS_OFS_EXCRET 8'h34
`define ISS_OFS_DBGRET 8'h38
`define ISS_OFS_STAT 8'h3C
`define ISS_OFS_MASK 8'h40

// event status bits
`define ISS_EVT_W 3
`define ISS_EVT_HW 0
`define ISS_EVT_EXC 1
`define ISS_EVT_DROP 2

// reset values
`define ISS_ENAB_RST 64'hC000_0000_0000_0000
`define ISS_EDGE_RST 64'h0FFF_FFFF_FFFF_FFFF
`define ISS_PC_RST 32'h0000_0000

`endif

// >>> common/iss_pkg.sv
// types for the interrupt service sequencer.
// assumes iss_cfg.svh is on the include path.
`include "iss_cfg.svh"
package iss_pkg;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FLIGHT = 1'b1
    } seq_state_t;

    typedef enum logic [1:0] {
        MODE_USER = 2'b00,
        MODE_SUPER = 2'b01,
        MODE_EMU = 2'b10
    } mode_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [`ISS_ADDR_W-1:0] addr;
        logic [`ISS_DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic valid;
        logic emu;
        logic [`ISS_PC_W-1:0] pc;
    } exc_req_t;
endpackage

// >>> core/interrupt_service_sequencer.sv
// interrupt entry, recheck, abort and return sequencing for a core.
// assumes the pipeline shares clk_i and resetn_i, so its inputs need no
// synchroniser; registers are reached over a plain strobe port.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iss_cfg.svh"
module interrupt_service_sequencer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire iss_pkg::bus_req_t bus_i,
    output logic [`ISS_DATA_W-1:0] rdata_o,
    input wire logic [`ISS_HW_TOP:0] irq_lines_i,
    input wire logic [`ISS_PC_W-1:0] next_pc_i,
    input wire logic first_ex2_i,
    input wire iss_pkg::exc_req_t exc_i,
    input wire logic alias_rd_i,
    input wire logic alias_wr_i,
    input wire logic [`ISS_PC_W-1:0] alias_wdata_i,
    input wire logic rti_i,
    output logic entry_o,
    output logic [5:0] entry_vec_o,
    output logic abort_o,
    output logic jump_o,
    output logic [`ISS_PC_W-1:0] jump_pc_o,
    output logic [`ISS_PC_W-1:0] alias_rdata_o,
    output iss_pkg::mode_t mode_o,
    output logic irq_o
);

    // ******************************************************
    // state and helpers
    // ******************************************************
    localparam int VW = `ISS_VEC_W;

    iss_pkg::seq_state_t state_q;
    logic [VW-1:0] pend_q, pend_d;
    logic [VW-1:0] enab_q;
    logic [VW-1:0] insvc_q, insvc_d;
    logic [VW-1:0] edge_q;
    logic [`ISS_HW_TOP:0] irq_prev_q;
    logic [5:0] vec_q;
    logic [`ISS_PC_W-1:0] cap_pc_q;
    logic [`ISS_PC_W-1:0] hw_ret_q, exc_ret_q, dbg_ret_q;
    logic [`ISS_EVT_W-1:0] stat_q, stat_d, mask_q;
    logic [`ISS_DATA_W-1:0] rdata_q;
    iss_pkg::mode_t mode_q;
    logic entry_q, abort_q, jump_q, irq_q;
    logic [5:0] entry_vec_q;
    logic [`ISS_PC_W-1:0] jump_pc_q;

    logic [VW-1:0] spm_v, cand_v, hw_set_v;
    logic [6:0] hw_sel, insvc_top;
    logic exc_take, take_hw, hw_commit, hw_drop, recheck_ok;

    // ones above the top set bit, zero at and below it
    function automatic logic [VW-1:0] prio_mask(input logic [VW-1:0] m);
        logic [VW-1:0] r;
        logic seen;
        r = '0;
        seen = 1'b0;
        for (int i = VW - 1; i >= 0; i--)
        begin
            if (m[i])
                seen = 1'b1;
            r[i] = ~seen;
        end
        return r;
    endfunction

    // {found, index}, highest index wins
    function automatic logic [6:0] top_bit(input logic [VW-1:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < VW; i++)
        begin
            if (v[i])
                r = {1'b1, 6'(i)};
        end
        return r;
    endfunction

    // ******************************************************
    // selection and decisions
    // ******************************************************
    // derived mask and masked pending vector, evaluated every cycle
    always_comb
    begin
        spm_v = prio_mask(insvc_q);
        if (insvc_q[`ISS_GLOBAL_BIT])
            spm_v[`ISS_HW_TOP:0] = '0;
        cand_v = pend_q & enab_q & spm_v;
        cand_v[VW-1:`ISS_GLOBAL_BIT] = '0;
        hw_sel = top_bit(cand_v);
        insvc_top = top_bit({insvc_q[VW-1:`ISS_EXC_BIT], 2'h0,
            insvc_q[`ISS_HW_TOP:0]}); // bits 61..60 are flags, not levels
    end

    // exceptions bypass both global bits; a disabled one is simply lost
    assign exc_take = exc_i.valid &&
        (exc_i.emu ? enab_q[`ISS_EMU_BIT] : enab_q[`ISS_EXC_BIT]);
    // no new hardware entry while one is in flight or bit 60 is held
    assign take_hw = (state_q == iss_pkg::ST_IDLE) && !exc_take &&
        enab_q[`ISS_GLOBAL_BIT] && hw_sel[6];
    // only the global bits are rechecked, not the entry's own enable bit
    assign recheck_ok = enab_q[`ISS_GLOBAL_BIT] &&
        !insvc_q[`ISS_GLOBAL_BIT];
    assign hw_commit = (state_q == iss_pkg::ST_FLIGHT) && first_ex2_i &&
        !exc_take && recheck_ok;
    assign hw_drop = (state_q == iss_pkg::ST_FLIGHT) && first_ex2_i &&
        !exc_take && !recheck_ok;

    // ******************************************************
    // entry sequencer
    // ******************************************************
    // exception pre-empts an in-flight entry, which goes back to idle
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= iss_pkg::ST_IDLE;
            vec_q <= 6'h00;
            cap_pc_q <= `ISS_PC_RST;
        end
        else if (state_q == iss_pkg::ST_IDLE)
        begin
            if (take_hw)
            begin
                state_q <= iss_pkg::ST_FLIGHT;
                vec_q <= hw_sel[5:0];
                cap_pc_q <= next_pc_i;
            end
        end
        else if (exc_take || first_ex2_i)
        begin
            state_q <= iss_pkg::ST_IDLE;
        end
    end

    // ******************************************************
    // pending latch
    // ******************************************************
    // hardware sets are applied last so they beat any clear
    always_comb
    begin
        hw_set_v = '0;
        pend_d = pend_q;
        if (bus_i.we)
        begin
            unique case (bus_i.addr)
                `ISS_OFS_PSET_LO: pend_d[31:0] = pend_q[31:0] | bus_i.wdata;
                `ISS_OFS_PSET_HI: pend_d[63:32] = pend_q[63:32] | bus_i.wdata;
                `ISS_OFS_PCLR_LO: pend_d[31:0] = pend_q[31:0] & bus_i.wdata;
                `ISS_OFS_PCLR_HI: pend_d[63:32] = pend_q[63:32] & bus_i.wdata;
                default: pend_d = pend_q;
            endcase
        end
        // an aborted entry leaves its bit alone so it is served later
        if (hw_commit && edge_q[vec_q])
            pend_d[vec_q] = 1'b0;
        for (int i = 0; i <= `ISS_HW_TOP; i++)
        begin
            if (edge_q[i])
            begin
                hw_set_v[i] = irq_lines_i[i] & ~irq_prev_q[i];
                pend_d[i] = pend_d[i] | hw_set_v[i];
            end
            else
            begin
                pend_d[i] = irq_lines_i[i];
            end
        end
        // exception bits are never latched: the faulting line is gone
        pend_d[VW-1:`ISS_GLOBAL_BIT] = '0;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pend_q <= '0;
            irq_prev_q <= '0;
        end
        else
        begin
            pend_q <= pend_d;
            irq_prev_q <= irq_lines_i;
        end
    end

    // ******************************************************
    // in-service mask
    // ******************************************************
    // clears first (return, alias read), then sets, so a set wins
    always_comb
    begin
        insvc_d = insvc_q;
        if (rti_i && insvc_top[6])
        begin
            insvc_d[insvc_top[5:0]] = 1'b0;
            if (insvc_top[5:0] < 6'(`ISS_EXC_BIT - 1))
                insvc_d[`ISS_GLOBAL_BIT] = 1'b0;
        end
        if (alias_rd_i)
            insvc_d[`ISS_GLOBAL_BIT] = 1'b0;
        if (alias_wr_i)
            insvc_d[`ISS_GLOBAL_BIT] = 1'b1;
        if (hw_commit)
        begin
            insvc_d[vec_q] = 1'b1;
            insvc_d[`ISS_GLOBAL_BIT] = 1'b1;
        end
        // exception entry marks its own bit and leaves bit 60 untouched
        if (exc_take)
        begin
            if (exc_i.emu)
                insvc_d[`ISS_EMU_BIT] = 1'b1;
            else
                insvc_d[`ISS_EXC_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            insvc_q <= '0;
        else
            insvc_q <= insvc_d;
    end

    // ******************************************************
    // return registers and mode
    // ******************************************************
    // hardware return written only at commit; alias write also loads it
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hw_ret_q <= `ISS_PC_RST;
            exc_ret_q <= `ISS_PC_RST;
            dbg_ret_q <= `ISS_PC_RST;
        end
        else
        begin
            if (alias_wr_i)
                hw_ret_q <= alias_wdata_i;
            else if (hw_commit)
                hw_ret_q <= cap_pc_q;
            if (exc_take && !exc_i.emu)
                exc_ret_q <= exc_i.pc;
            if (exc_take && exc_i.emu)
                dbg_ret_q <= exc_i.pc;
        end
    end

    // back to user mode only when nothing is left in service
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mode_q <= iss_pkg::MODE_USER;
        else if (exc_take && exc_i.emu)
            mode_q <= iss_pkg::MODE_EMU;
        else if (exc_take || hw_commit)
            mode_q <= iss_pkg::MODE_SUPER;
        else if (rti_i && insvc_d == '0)
            mode_q <= iss_pkg::MODE_USER;
    end

    // ******************************************************
    // pipeline outputs
    // ******************************************************
    // one-cycle pulses; abort covers exception flush and failed recheck
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            entry_q <= 1'b0;
            entry_vec_q <= 6'h00;
            abort_q <= 1'b0;
            jump_q <= 1'b0;
            jump_pc_q <= `ISS_PC_RST;
        end
        else
        begin
            entry_q <= take_hw;
            if (take_hw)
                entry_vec_q <= hw_sel[5:0];
            abort_q <= exc_take || hw_drop;
            jump_q <= rti_i;
            if (rti_i)
                jump_pc_q <= hw_ret_q;
        end
    end

    // ******************************************************
    // register port and interrupt output
    // ******************************************************
    // configuration writes
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            enab_q <= `ISS_ENAB_RST;
            edge_q <= `ISS_EDGE_RST;
            mask_q <= '0;
        end
        else if (bus_i.we)
        begin
            unique case (bus_i.addr)
                `ISS_OFS_ENAB_LO: enab_q[31:0] <= bus_i.wdata;
                `ISS_OFS_ENAB_HI: enab_q[63:32] <= bus_i.wdata;
                `ISS_OFS_EDGE_LO: edge_q[31:0] <= bus_i.wdata;
                `ISS_OFS_EDGE_HI: edge_q[63:32] <= bus_i.wdata;
                `ISS_OFS_MASK: mask_q <= bus_i.wdata[`ISS_EVT_W-1:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    // sticky events; read clears, but an event in that cycle survives
    always_comb
    begin
        stat_d = stat_q;
        if (bus_i.re && bus_i.addr == `ISS_OFS_STAT)
            stat_d = '0;
        stat_d[`ISS_EVT_HW] = stat_d[`ISS_EVT_HW] | hw_commit;
        stat_d[`ISS_EVT_EXC] = stat_d[`ISS_EVT_EXC] | exc_take;
        stat_d[`ISS_EVT_DROP] = stat_d[`ISS_EVT_DROP] | hw_drop;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            stat_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
        end
    end

    // read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rdata_q <= '0;
        else if (bus_i.re)
        begin
            unique case (bus_i.addr)
                `ISS_OFS_PEND_LO: rdata_q <= pend_q[31:0];
                `ISS_OFS_PEND_HI: rdata_q <= pend_q[63:32];
                `ISS_OFS_ENAB_LO: rdata_q <= enab_q[31:0];
                `ISS_OFS_ENAB_HI: rdata_q <= enab_q[63:32];
                `ISS_OFS_INSV_LO: rdata_q <= insvc_q[31:0];
                `ISS_OFS_INSV_HI: rdata_q <= insvc_q[63:32];
                `ISS_OFS_EDGE_LO: rdata_q <= edge_q[31:0];
                `ISS_OFS_EDGE_HI: rdata_q <= edge_q[63:32];
                `ISS_OFS_HWRET: rdata_q <= hw_ret_q;
                `ISS_OFS_EXCRET: rdata_q <= exc_ret_q;
                `ISS_OFS_DBGRET: rdata_q <= dbg_ret_q;
                `ISS_OFS_STAT: rdata_q <= {29'h0000_0000, stat_q};
                `ISS_OFS_MASK: rdata_q <= {29'h0000_0000, mask_q};
                default: rdata_q <= '0;
            endcase
        end
        else
            rdata_q <= '0;
    end

    assign rdata_o = rdata_q;
    assign entry_o = entry_q;
    assign entry_vec_o = entry_vec_q;
    assign abort_o = abort_q;
    assign jump_o = jump_q;
    assign jump_pc_o = jump_pc_q;
    assign alias_rdata_o = hw_ret_q;
    assign mode_o = mode_q;
    assign irq_o = irq_q;

    // ******************************************************
    // checks
    // ******************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_entry_issued;
        entry_o && state_q == iss_pkg::ST_FLIGHT;
    endsequence

    sequence s_entry_abandoned;
        abort_o && state_q == iss_pkg::ST_IDLE;
    endsequence

    chk_entry_pulse_flight: assert property (
        take_hw |=> s_entry_issued)
        else $error("entry not issued after selection");

    chk_global_blocks_hw: assert property (
        insvc_q[`ISS_GLOBAL_BIT] |-> !take_hw && spm_v[`ISS_HW_TOP:0] == '0)
        else $error("hardware taken while global in-service set");

    chk_commit_sets_insvc: assert property (
        hw_commit |=> insvc_q[vec_q] && insvc_q[`ISS_GLOBAL_BIT])
        else $error("commit did not set in-service bits");

    chk_commit_ret_write: assert property (
        hw_commit && !alias_wr_i |=> hw_ret_q == $past(cap_pc_q))
        else $error("return register not loaded at commit");

    chk_edge_pend_clear: assert property (
        hw_commit && edge_q[vec_q] && !hw_set_v[vec_q] && !bus_i.we
        |=> !pend_q[vec_q])
        else $error("edge pending bit not cleared at commit");

    chk_exc_abort_keep: assert property (
        exc_take && state_q == iss_pkg::ST_FLIGHT && pend_q[vec_q] &&
        edge_q[vec_q] && !bus_i.we |=> abort_o && pend_q[vec_q] &&
        state_q == iss_pkg::ST_IDLE)
        else $error("exception did not abort entry or lost pending");

    chk_recheck_abandon: assert property (
        hw_drop |=> s_entry_abandoned ##1 !abort_o [*2])
        else $error("failed recheck did not abandon entry");

    chk_exc_no_global: assert property (
        exc_take && !hw_commit && !alias_wr_i && !alias_rd_i && !rti_i
        |=> $stable(insvc_q[`ISS_GLOBAL_BIT]))
        else $error("exception changed global in-service bit");

    chk_alias_read_clear: assert property (
        alias_rd_i && !alias_wr_i && !hw_commit |=> !insvc_q[`ISS_GLOBAL_BIT])
        else $error("alias read did not clear global bit");

    chk_rti_hw_clear: assert property (
        rti_i && insvc_top[6] && insvc_top[5:0] < 6'(`ISS_GLOBAL_BIT) &&
        !alias_wr_i && !hw_commit
        |=> !insvc_q[`ISS_GLOBAL_BIT] ##0 jump_o ##1 !jump_o)
        else $error("return did not clear global bit or jump");

    chk_emu_mode_ret: assert property (
        exc_take && exc_i.emu |=> mode_o == iss_pkg::MODE_EMU &&
        dbg_ret_q == $past(exc_i.pc))
        else $error("emulation entry mode or return wrong");

endmodule
`default_nettype wire

// >>> verification/pipeline_model.sv
// model of the core pipeline that stands behind the sequencer.
// assumes it shares clk_i and resetn_i with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module pipeline_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic entry_i,
    input wire logic abort_i,
    input wire logic [7:0] delay_i,
    output logic first_ex2_o
);
    logic busy_q;
    logic [7:0] cnt_q;
    // handler op reaches stage two delay_i + 1 cycles after the edge that samples entry; a flush
    // kills it, so no report may follow an abort
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            first_ex2_o <= 1'b0;
        end
        else
        begin
            first_ex2_o <= 1'b0;
            if (abort_i)
                busy_q <= 1'b0;
            else if (entry_i)
            begin
                busy_q <= 1'b1;
                cnt_q <= delay_i;
            end
            else if (busy_q && cnt_q == 8'h00)
            begin
                first_ex2_o <= 1'b1;
                busy_q <= 1'b0;
            end
            else if (busy_q)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_interrupt_service_sequencer.sv
// self-checking bench for the interrupt service sequencer.
// assumes the package is compiled first and common/ is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "iss_cfg.svh"
module tb_interrupt_service_sequencer;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    iss_pkg::bus_req_t bus = '0;
    iss_pkg::exc_req_t exc = '0;
    iss_pkg::mode_t mode;
    logic [59:0] irq = '0;
    logic [31:0] npc = 32'h0000_1000;
    logic [31:0] awd = 32'h0000_2222;
    logic [7:0] dly = 8'h03;
    logic ard = 1'b0;
    logic awr = 1'b0;
    logic return_from_interrupt_op = 1'b0;
    logic fex2, entry, abort, jump, irq_o;
    logic [31:0] rdata, jpc, ardata;
    logic [5:0] vec;
    int err_count = 0;
    int check_count = 0;
    int n_ent = 0;
    int n_abt = 0;
    // writable places read back; read-only and unmapped places must ignore writes
    row_t rows [6] = '{
        '{`ISS_OFS_ENAB_LO, 32'h0000_0028, 32'h0000_0028},
        '{`ISS_OFS_MASK, 32'h0000_0007, 32'h0000_0007},
        '{`ISS_OFS_EDGE_HI, 32'h0FFF_FFFF, 32'h0FFF_FFFF},
        '{`ISS_OFS_PEND_LO, 32'h0000_FFFF, 32'h0000_0000},
        '{`ISS_OFS_HWRET, 32'h0000_0055, 32'h0000_0000},
        '{8'h44, 32'h0000_0001, 32'h0000_0000}};

    interrupt_service_sequencer i_interrupt_service_sequencer (
        .clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
        .irq_lines_i(irq), .next_pc_i(npc), .first_ex2_i(fex2),
        .exc_i(exc), .alias_rd_i(ard), .alias_wr_i(awr),
        .alias_wdata_i(awd), .rti_i(return_from_interrupt_op), .entry_o(entry),
        .entry_vec_o(vec), .abort_o(abort), .jump_o(jump),
        .jump_pc_o(jpc), .alias_rdata_o(ardata), .mode_o(mode),
        .irq_o(irq_o));
    pipeline_model i_pipeline_model (
        .clk_i(clk_i), .resetn_i(resetn_i), .entry_i(entry),
        .abort_i(abort), .delay_i(dly), .first_ex2_o(fex2));

    initial forever #2.5 clk_i = ~clk_i;
    // registered pulses are counted at the edge after they rise
    always @(posedge clk_i)
    begin
        n_ent += (entry === 1'b1);
        n_abt += (abort === 1'b1);
    end

    // ************
    // shared tasks
    // ************
    task chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) bus <= {1'b1, 1'b0, a, d};
        @(posedge clk_i) bus <= '0;
    endtask
    // read data stands only in the cycle after the strobe
    task rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i) bus <= {1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk_i) bus <= '0;
        #1 chk(rdata, e);
    endtask
    task pulse(input int k);
        @(posedge clk_i);
        ard <= (k == 0);
        awr <= (k == 1);
        return_from_interrupt_op <= (k == 2);
        @(posedge clk_i);
        {ard, awr, return_from_interrupt_op} <= 3'h0;
        #1;
    endtask
    task xc(input logic emu, input logic [31:0] pc);
        @(posedge clk_i) exc <= {1'b1, emu, pc};
        @(posedge clk_i) exc <= '0;
        #1;
    endtask
    // bounded wait, since a lost entry must not hang the run
    task wait_ent(input int n, input logic [5:0] v);
        for (int i = 0; i < 40 && n_ent < n; i++)
            @(posedge clk_i);
        #1 chk(vec, v);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_count++;
        end_of_test;
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        rchk(`ISS_OFS_ENAB_HI, 32'hC000_0000);
        rchk(`ISS_OFS_EDGE_LO, 32'hFFFF_FFFF);
        chk(mode, iss_pkg::MODE_USER);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rchk(rows[i].a, rows[i].e);
        end
        $display("test registers done");
        wr(`ISS_OFS_ENAB_HI, 32'hD000_0000);
        @(posedge clk_i) irq <= 60'h000_0000_0000_0028;
        wait_ent(1, 6'h05);
        repeat (6) @(posedge clk_i);
        rchk(`ISS_OFS_INSV_HI, 32'h1000_0000);
        rchk(`ISS_OFS_INSV_LO, 32'h0000_0020);
        rchk(`ISS_OFS_PEND_LO, 32'h0000_0008);
        rchk(`ISS_OFS_HWRET, 32'h0000_1000);
        chk(mode, iss_pkg::MODE_SUPER);
        repeat (10) @(posedge clk_i);
        chk(n_ent, 1);
        pulse(0);
        rchk(`ISS_OFS_INSV_HI, 32'h0000_0000);
        repeat (10) @(posedge clk_i);
        chk(n_ent, 1);
        pulse(1);
        chk(ardata, 32'h0000_2222);
        rchk(`ISS_OFS_INSV_HI, 32'h1000_0000);
        @(posedge clk_i) dly <= 8'h0C;
        pulse(2);
        chk({jump, jpc}, 33'h1_0000_2222);
        chk(mode, iss_pkg::MODE_USER);
        rchk(`ISS_OFS_INSV_LO, 32'h0000_0000);
        rchk(`ISS_OFS_INSV_HI, 32'h0000_0000);
        $display("test hardware entry done");
        // exception lands while the lower entry is still in flight
        wait_ent(2, 6'h03);
        xc(1'b0, 32'h0000_3000);
        chk(abort, 1'b1);
        rchk(`ISS_OFS_PEND_LO, 32'h0000_0008);
        rchk(`ISS_OFS_EXCRET, 32'h0000_3000);
        rchk(`ISS_OFS_INSV_HI, 32'h4000_0000);
        chk(mode, iss_pkg::MODE_SUPER);
        repeat (10) @(posedge clk_i);
        chk(n_ent, 2);
        @(posedge clk_i) dly <= 8'h04;
        pulse(2);
        chk(mode, iss_pkg::MODE_USER);
        wait_ent(3, 6'h03);
        wr(`ISS_OFS_ENAB_LO, 32'h0000_0020);
        repeat (8) @(posedge clk_i);
        rchk(`ISS_OFS_INSV_LO, 32'h0000_0008);
        rchk(`ISS_OFS_PEND_LO, 32'h0000_0000);
        pulse(2);
        $display("test exception abort done");
        // global enable dropped in flight makes the recheck fail
        chk(irq_o, 1'b1);
        rchk(`ISS_OFS_STAT, 32'h0000_0003);
        @(posedge clk_i) dly <= 8'h0C;
        #1 chk(irq_o, 1'b0);
        wr(`ISS_OFS_PSET_LO, 32'h0000_0020);
        wait_ent(4, 6'h05);
        wr(`ISS_OFS_ENAB_HI, 32'hC000_0000);
        repeat (16) @(posedge clk_i);
        chk(n_abt, 2);
        rchk(`ISS_OFS_STAT, 32'h0000_0004);
        xc(1'b1, 32'h0000_4000);
        chk({abort, mode},
            {1'b1, iss_pkg::MODE_EMU});
        rchk(`ISS_OFS_DBGRET, 32'h0000_4000);
        rchk(`ISS_OFS_INSV_HI, 32'h8000_0000);
        pulse(2);
        chk(mode, iss_pkg::MODE_USER);
        wr(`ISS_OFS_ENAB_HI, 32'h0000_0000);
        xc(1'b0, 32'h0000_5000);
        chk(abort, 1'b0);
        rchk(`ISS_OFS_EXCRET, 32'h0000_3000);
        $display("test recheck and emulation done");
        // a reset in mid-run must bring every state back to its reset value
        @(posedge clk_i) resetn_i <= 1'b0;
        @(posedge clk_i) resetn_i <= 1'b1;
        #1 chk({mode, irq_o, abort, jump}, 5'h00);
        rchk(`ISS_OFS_ENAB_HI, 32'hC000_0000);
        rchk(`ISS_OFS_HWRET, 32'h0000_0000);
        rchk(`ISS_OFS_INSV_HI, 32'h0000_0000);
        $display("test mid-run reset done");
        end_of_test;
    end
endmodule
`default_nettype wire
